/* File: core/transfer_header_block.v */
`timescale 1ns/100ps
`include "tdh_defines.vh"
module transfer_header_block (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_b_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output wire [31:0] hrdata_out,
  // Frame timer
  input  wire        frame_tick_in,
  // Packet engine request
  output wire        pkt_req_out,
  output wire [1:0]  pkt_token_out,
  output wire [6:0]  pkt_dev_addr_out,
  output wire [3:0]  pkt_ep_out,
  output wire        pkt_low_speed_out,
  output wire        pkt_toggle_out,
  output wire [9:0]  pkt_len_out,
  output wire [8:0]  pkt_buf_addr_out,
  // Packet engine answer
  input  wire        pkt_done_in,
  input  wire        pkt_retry_in,
  input  wire [3:0]  pkt_outcome_in,
  input  wire [9:0]  pkt_bytes_in,
  input  wire        pkt_rx_toggle_in
);

  localparam BUS_IDLE = 3'b001;
  localparam BUS_RD1  = 3'b010;
  localparam BUS_RD2  = 3'b100;

  localparam ST_IDLE   = 8'b0000_0001;
  localparam ST_RD0    = 8'b0000_0010;
  localparam ST_RD1    = 8'b0000_0100;
  localparam ST_RD2    = 8'b0000_1000;
  localparam ST_DECIDE = 8'b0001_0000;
  localparam ST_PKT    = 8'b0010_0000;
  localparam ST_WB     = 8'b0100_0000;
  localparam ST_NEXT   = 8'b1000_0000;

  localparam LIST_ISO  = 3'b001;
  localparam LIST_INT  = 3'b010;
  localparam LIST_APER = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function [9:0] min10;
    input [9:0] a;
    input [9:0] b;
    begin
      min10 = (a < b) ? a : b;
    end
  endfunction

  // Word address of a header; each slot is eight words
  function [6:0] slot_base;
    input [2:0] lst;
    input [2:0] s;
    begin
      if (lst[0]) begin
        slot_base = `ISO_BASE | {1'b0, s, 3'b000};
      end else if (lst[1]) begin
        slot_base = `INT_BASE | {2'b00, s[1:0], 3'b000};
      end else begin
        slot_base = `APER_BASE | {2'b00, s[1:0], 3'b000};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [2:0]  bus_st_r;
  reg         dph_wr_r;
  reg  [9:0]  dph_addr_r;
  reg  [31:0] hrdata_r;
  reg  [2:0]  ctrl_r;
  reg  [1:0]  aper_end_r;
  reg  [1:0]  per_end_r;
  reg  [7:0]  frame_r;

  reg  [7:0]  eng_st_r;
  reg  [2:0]  list_r;
  reg  [2:0]  slot_r;
  reg  [31:0] w0_r;
  reg  [31:0] w1_r;
  reg  [9:0]  moved_r;
  reg  [9:0]  plen_r;
  reg  [8:0]  buf_addr_r;
  reg         tog_r;
  reg         go_r;
  reg  [3:0]  code_r;
  reg         pend_r;
  reg         ping_wait_r;

  wire [31:0] mem_a_rdata;
  wire [31:0] mem_b_rdata;
  reg  [6:0]  mem_b_addr;
  reg         mem_b_we;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads two wait states

  wire bus_acc  = hsel_in & htrans_in[1] & hready_in;
  wire reg_wr   = dph_wr_r & ~dph_addr_r[`MEM_SEL_BIT];
  wire mem_a_we = dph_wr_r & dph_addr_r[`MEM_SEL_BIT];

  assign hreadyout_out = bus_st_r[0];
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_r;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_st_r   <= BUS_IDLE;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 10'h000;
    end else begin
      dph_wr_r <= 1'b0;
      case (bus_st_r)
        BUS_IDLE: begin
          if (bus_acc) begin
            dph_addr_r <= {haddr_in[9:2], 2'b00};
            dph_wr_r   <= hwrite_in;
            bus_st_r   <= hwrite_in ? BUS_IDLE : BUS_RD1;
          end
        end
        BUS_RD1: bus_st_r <= BUS_RD2;
        BUS_RD2: bus_st_r <= BUS_IDLE;
        default: bus_st_r <= BUS_IDLE;
      endcase
    end
  end

  reg [31:0] reg_rdata;
  always @* begin
    case (dph_addr_r)
      `REG_CTRL:     reg_rdata = {29'h0, ctrl_r};
      `REG_APER_END: reg_rdata = {30'h0, aper_end_r};
      `REG_PER_END:  reg_rdata = {30'h0, per_end_r};
      `REG_FRAME:    reg_rdata = {24'h0, frame_r};
      `REG_STATUS:   reg_rdata = {16'h0, code_r, 1'b0, list_r, 1'b0, slot_r,
                                  1'b0, pend_r, ping_wait_r, ~eng_st_r[0]};
      default:       reg_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_r <= 32'h0000_0000;
    end else if (bus_st_r[2]) begin
      hrdata_r <= dph_addr_r[`MEM_SEL_BIT] ? mem_a_rdata : reg_rdata;
    end
  end

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r     <= `CTRL_RST;
      aper_end_r <= `END_RST;
      per_end_r  <= `END_RST;
      frame_r    <= `FRAME_RST;
    end else begin
      if (reg_wr && dph_addr_r == `REG_CTRL) begin
        ctrl_r <= hwdata_in[2:0];
      end
      if (reg_wr && dph_addr_r == `REG_APER_END) begin
        aper_end_r <= hwdata_in[1:0];
      end
      if (reg_wr && dph_addr_r == `REG_PER_END) begin
        per_end_r <= hwdata_in[1:0];
      end
      // The frame timer wins over a software load in the same cycle
      if (frame_tick_in) begin
        frame_r <= frame_r + 8'h01;
      end else if (reg_wr && dph_addr_r == `REG_FRAME) begin
        frame_r <= hwdata_in[7:0];
      end
    end
  end

  tdh_buffer_ram u_ram (
    .clk_sys_in  (clk_sys_in),
    .a_addr_in   (dph_addr_r[8:2]),
    .a_we_in     (mem_a_we),
    .a_wdata_in  (hwdata_in),
    .a_rdata_out (mem_a_rdata),
    .b_addr_in   (mem_b_addr),
    .b_we_in     (mem_b_we),
    .b_wdata_in  ({w0_r[`W0_KEEP_MSB:`W0_KEEP_LSB], code_r, go_r, tog_r, moved_r}),
    .b_rdata_out (mem_b_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Header field decode

  wire [9:0] hdr_cnt    = w0_r[`W0_CNT_MSB:`W0_CNT_LSB];
  wire       hdr_go     = w0_r[`W0_GO_BIT];
  wire [9:0] hdr_limit  = w0_r[`W0_LIM_MSB:`W0_LIM_LSB];
  wire       hdr_last   = w0_r[`W0_LAST_BIT];
  wire [9:0] hdr_len    = w1_r[`W1_LEN_MSB:`W1_LEN_LSB];
  wire [1:0] hdr_token  = w1_r[`W1_TOK_MSB:`W1_TOK_LSB];
  wire       hdr_bufsel = w1_r[`W1_BUFSEL_BIT];
  wire       hdr_paired = w1_r[`W1_PAIRED_BIT];
  wire [7:0] hdr_b7     = w1_r[`W1_B7_MSB:`W1_B7_LSB];

  wire is_iso  = list_r[0];
  wire is_int  = list_r[1];
  wire is_aper = list_r[2];

  wire list_on = (is_iso & ctrl_r[`CTRL_ISO_ON]) | (is_int & ctrl_r[`CTRL_INT_ON]) |
                 (is_aper & ctrl_r[`CTRL_APER_ON]);

  // Interrupt polling: frames every 2^rate, capped at 32 frames for rate above 4, phase from low first_frame bits
  wire [2:0] poll_interval = hdr_b7[7:5];
  wire [7:0] poll_mask8    = (8'h01 << poll_interval) - 8'h01;
  wire [4:0] poll_mask     = (poll_interval > 3'h4) ? 5'h1f : poll_mask8[4:0];
  wire       poll_hit      = ((frame_r[4:0] ^ hdr_b7[4:0]) & poll_mask) == 5'h00;

  wire iso_hit   = hdr_b7 == frame_r;
  wire pong_wait = hdr_paired & hdr_bufsel & ping_wait_r;
  wire skip_desc = ~list_on | ~hdr_go |
                   (is_iso & ~iso_hit) | (is_int & ~poll_hit) | (is_aper & pong_wait);

  // Only the isochronous list honours the in-header last flag
  wire list_done = ~list_on |
                   (is_iso & (hdr_last | slot_r == `ISO_LAST_SLOT)) |
                   (is_int & slot_r[1:0] == per_end_r) |
                   (is_aper & slot_r[1:0] == aper_end_r);

  ////////////////////////////////////////////////////////////////////////////
  // Packet results

  wire [9:0]  eff_bytes  = min10(pkt_bytes_in, plen_r);
  wire [10:0] moved_sum  = {1'b0, moved_r} + {1'b0, eff_bytes};
  wire [9:0]  remain_nxt = hdr_len - moved_sum[9:0];
  wire        xfer_end   = (moved_sum >= {1'b0, hdr_len}) | (eff_bytes < plen_r);
  wire        tog_bad    = (hdr_token == `TOKEN_IN) & (pkt_rx_toggle_in != tog_r);

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine

  always @* begin
    mem_b_addr = slot_base(list_r, slot_r);
    mem_b_we   = 1'b0;
    if (eng_st_r == ST_RD1) begin
      mem_b_addr = slot_base(list_r, slot_r) + 7'h01;
    end
    if (eng_st_r == ST_WB) begin
      mem_b_we = 1'b1;
    end
  end

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eng_st_r    <= ST_IDLE;
      list_r      <= LIST_ISO;
      slot_r      <= 3'h0;
      w0_r        <= 32'h0000_0000;
      w1_r        <= 32'h0000_0000;
      moved_r     <= 10'h000;
      plen_r      <= 10'h000;
      buf_addr_r  <= 9'h000;
      tog_r       <= 1'b0;
      go_r        <= 1'b0;
      code_r      <= `OUTCOME_OK;
      pend_r      <= 1'b0;
      ping_wait_r <= 1'b0;
    end else begin
      // A frame that starts mid-scan is remembered, not lost
      if (frame_tick_in && !eng_st_r[0]) begin
        pend_r <= 1'b1;
      end
      case (eng_st_r)
        ST_IDLE: begin
          if (frame_tick_in || pend_r) begin
            pend_r   <= 1'b0;
            list_r   <= LIST_ISO;
            slot_r   <= 3'h0;
            eng_st_r <= ST_RD0;
          end
        end
        ST_RD0: eng_st_r <= ST_RD1;
        ST_RD1: begin
          w0_r     <= mem_b_rdata;
          eng_st_r <= ST_RD2;
        end
        ST_RD2: begin
          w1_r     <= mem_b_rdata;
          eng_st_r <= ST_DECIDE;
        end
        ST_DECIDE: begin
          if (skip_desc) begin
            eng_st_r <= ST_NEXT;
          end else begin
            moved_r    <= hdr_cnt;
            tog_r      <= w0_r[`W0_TOG_BIT];
            go_r       <= 1'b1;
            code_r     <= w0_r[`W0_CODE_MSB:`W0_CODE_LSB];
            plen_r     <= min10(hdr_limit, hdr_len - hdr_cnt);
            buf_addr_r <= {slot_base(list_r, slot_r), 2'b00} + `HDR_BYTES + hdr_cnt[8:0];
            eng_st_r   <= ST_PKT;
          end
        end
        ST_PKT: begin
          if (pkt_done_in) begin
            if (pkt_retry_in) begin
              // Retry later: go stays set, nothing moved
              code_r   <= pkt_outcome_in;
              eng_st_r <= ST_WB;
            end else if (pkt_outcome_in != `OUTCOME_OK) begin
              code_r   <= pkt_outcome_in;
              go_r     <= 1'b0;
              eng_st_r <= ST_WB;
            end else if (tog_bad) begin
              code_r   <= `OUTCOME_TOGGLE;
              go_r     <= 1'b0;
              eng_st_r <= ST_WB;
            end else begin
              code_r     <= `OUTCOME_OK;
              tog_r      <= ~tog_r;
              moved_r    <= moved_sum[9:0];
              buf_addr_r <= buf_addr_r + eff_bytes[8:0];
              if (xfer_end || is_iso) begin
                go_r     <= 1'b0;
                eng_st_r <= ST_WB;
              end else if (is_aper) begin
                plen_r <= min10(hdr_limit, remain_nxt);
              end else begin
                eng_st_r <= ST_WB;
              end
            end
          end
        end
        ST_WB: begin
          if (is_aper && hdr_paired && !hdr_bufsel) begin
            ping_wait_r <= go_r;
          end
          eng_st_r <= ST_NEXT;
        end
        ST_NEXT: begin
          if (list_done) begin
            if (is_aper) begin
              eng_st_r <= ST_IDLE;
            end else begin
              list_r   <= {list_r[1:0], 1'b0};
              slot_r   <= 3'h0;
              eng_st_r <= ST_RD0;
            end
          end else begin
            slot_r   <= slot_r + 3'h1;
            eng_st_r <= ST_RD0;
          end
        end
        default: eng_st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet engine request; data held in flops for the whole request

  assign pkt_req_out       = eng_st_r[5];
  assign pkt_token_out     = hdr_token;
  assign pkt_dev_addr_out  = w1_r[`W1_ADDR_MSB:`W1_ADDR_LSB];
  assign pkt_ep_out        = w0_r[`W0_EP_MSB:`W0_EP_LSB];
  assign pkt_low_speed_out = w0_r[`W0_SPEED_BIT];
  assign pkt_toggle_out    = tog_r;
  assign pkt_len_out       = plen_r;
  assign pkt_buf_addr_out  = buf_addr_r;

endmodule

/* File: core/tdh_defines.vh */
`ifndef TDH_DEFINES_VH
`define TDH_DEFINES_VH

// Register byte offsets; haddr bit 9 selects the descriptor buffer
`define REG_CTRL        10'h000
`define REG_APER_END    10'h004
`define REG_PER_END     10'h008
`define REG_FRAME       10'h00c
`define REG_STATUS      10'h010
`define MEM_SEL_BIT     9

// Reset values
`define CTRL_RST        3'h0
`define END_RST         2'h0
`define FRAME_RST       8'h00

// Control bits
`define CTRL_APER_ON    2
`define CTRL_INT_ON     1
`define CTRL_ISO_ON     0

// Header word 0 (bytes 0..3)
`define W0_CNT_MSB      9
`define W0_CNT_LSB      0
`define W0_TOG_BIT      10
`define W0_GO_BIT       11
`define W0_CODE_MSB     15
`define W0_CODE_LSB     12
`define W0_LIM_MSB      25
`define W0_LIM_LSB      16
`define W0_SPEED_BIT    26
`define W0_LAST_BIT     27
`define W0_EP_MSB       31
`define W0_EP_LSB       28
`define W0_KEEP_MSB     31
`define W0_KEEP_LSB     16

// Header word 1 (bytes 4..7)
`define W1_LEN_MSB      9
`define W1_LEN_LSB      0
`define W1_TOK_MSB      11
`define W1_TOK_LSB      10
`define W1_BUFSEL_BIT   14
`define W1_PAIRED_BIT   15
`define W1_ADDR_MSB     22
`define W1_ADDR_LSB     16
`define W1_B7_MSB       31
`define W1_B7_LSB       24

// Descriptor slots: eight words each, header first
`define SLOT_WORDS      3
`define HDR_BYTES       9'h008
`define APER_BASE       7'h00
`define INT_BASE        7'h20
`define ISO_BASE        7'h40
`define ISO_LAST_SLOT   3'h7

// Codes
`define TOKEN_IN        2'h2
`define OUTCOME_OK      4'h0
`define OUTCOME_TOGGLE  4'h3

`endif

/* File: core/tdh_buffer_ram.v */
`timescale 1ns/100ps
// Descriptor buffer, two independent ports, registered read data
module tdh_buffer_ram (
  // Clock
  input  wire        clk_sys_in,
  // Port a
  input  wire [6:0]  a_addr_in,
  input  wire        a_we_in,
  input  wire [31:0] a_wdata_in,
  output reg  [31:0] a_rdata_out,
  // Port b
  input  wire [6:0]  b_addr_in,
  input  wire        b_we_in,
  input  wire [31:0] b_wdata_in,
  output reg  [31:0] b_rdata_out
);

  reg [31:0] mem_r [0:127];

  // One process owns the array; port b wins a same-word write, software keeps off live headers
  always @(posedge clk_sys_in) begin
    if (a_we_in) begin
      mem_r[a_addr_in] <= a_wdata_in;
    end
    if (b_we_in) begin
      mem_r[b_addr_in] <= b_wdata_in;
    end
    a_rdata_out <= mem_r[a_addr_in];
    b_rdata_out <= mem_r[b_addr_in];
  end

endmodule

/* File: verif/thb_props.sv */
`timescale 1ns/100ps
module thb_props (
  // Clock and reset
  input wire        clk_sys_in,
  input wire        rst_b_in,
  // Bus
  input wire        hsel_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire [31:0] hrdata_out,
  // Packet engine
  input wire        pkt_req_out,
  input wire [1:0]  pkt_token_out,
  input wire [6:0]  pkt_dev_addr_out,
  input wire [3:0]  pkt_ep_out,
  input wire        pkt_low_speed_out,
  input wire        pkt_toggle_out,
  input wire [9:0]  pkt_len_out,
  input wire [8:0]  pkt_buf_addr_out,
  input wire        pkt_done_in,
  input wire        pkt_retry_in,
  input wire [3:0]  pkt_outcome_in,
  input wire [9:0]  pkt_bytes_in
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire       rd_acc = hsel_in && htrans_in[1] && hready_in && hreadyout_out && !hwrite_in;
  wire       good   = pkt_req_out && pkt_done_in && !pkt_retry_in && pkt_outcome_in == 4'h0;
  // Bytes credited per packet are clamped to the offered length
  wire [9:0] step   = (pkt_bytes_in < pkt_len_out) ? pkt_bytes_in : pkt_len_out;
  //////////////////////////////////////////////////////////////////////////////
  property p_resp; hresp_out == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("hresp not okay");
  property p_rd_wait; rd_acc |=> !hreadyout_out ##1 !hreadyout_out ##1 hreadyout_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_rd_hold; !$stable(hrdata_out) |-> !$past(hreadyout_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_req_hold; pkt_req_out && !pkt_done_in |=> pkt_req_out; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_req_stable;
    pkt_req_out && !pkt_done_in |=> $stable({pkt_token_out, pkt_dev_addr_out, pkt_ep_out,
      pkt_low_speed_out, pkt_toggle_out, pkt_len_out, pkt_buf_addr_out});
  endproperty
  a_req_stable: assert property (p_req_stable) else $error("request moved");
  property p_tog_flip;
    good && pkt_token_out != 2'h2 |=> !pkt_req_out || pkt_toggle_out != $past(pkt_toggle_out);
  endproperty
  a_tog_flip: assert property (p_tog_flip) else $error("toggle not flipped");
  property p_len_bound; good |=> !pkt_req_out || pkt_len_out <= $past(pkt_len_out); endproperty
  a_len_bound: assert property (p_len_bound) else $error("packet grew");
  property p_buf_step;
    good |=> !pkt_req_out || pkt_buf_addr_out == $past(pkt_buf_addr_out) + $past(step[8:0]);
  endproperty
  a_buf_step: assert property (p_buf_step) else $error("payload step wrong");
endmodule
bind transfer_header_block thb_props u_props (.*);

/* File: verif/pkt_engine_model.sv */
`timescale 1ns/100ps
module pkt_engine_model (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_b_in,
  // Request
  input  wire       req_in,
  input  wire [9:0] len_in,
  input  wire       toggle_in,
  // Test knobs
  input  wire [3:0] delay_in,
  input  wire [3:0] outcome_in,
  input  wire       bad_tog_in,
  input  wire       retry_in,
  // Answer
  output wire       done_out,
  output wire       retry_out,
  output wire [3:0] outcome_out,
  output wire [9:0] bytes_out,
  output wire       rx_toggle_out
);
  reg [3:0] cnt_r;
  reg       done_r;
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= req_in && !done_r && cnt_r == delay_in;
      cnt_r  <= (!req_in || done_r) ? 4'h0 : cnt_r + 4'h1;
    end
  end
  // Outside the done pulse the answer lines carry junk, never a stale copy
  assign done_out      = done_r;
  assign retry_out     = done_r ? retry_in : cnt_r[0];
  assign outcome_out   = done_r ? outcome_in : ~outcome_in;
  assign bytes_out     = done_r ? len_in : ~len_in;
  assign rx_toggle_out = done_r ? toggle_in ^ bad_tog_in : ~toggle_in;
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`include "tdh_defines.vh"
module testbench;
  reg         clk_sys_in = 1'b0;
  reg         rst_b_in   = 1'b0;
  reg         hsel       = 1'b0;
  reg         hwrite     = 1'b0;
  reg         tick       = 1'b0;
  reg         bad_tog    = 1'b0;
  reg         retry_knob = 1'b0;
  reg  [1:0]  htrans     = 2'h0;
  reg  [3:0]  dly        = 4'h1;
  reg  [3:0]  oc         = 4'h0;
  reg  [31:0] haddr      = 32'h0;
  reg  [31:0] hwdata     = 32'h0;
  reg  [31:0] q;
  wire        hready, hresp, req, low, tog, done, retry, rxt;
  wire [31:0] hrdata;
  wire [1:0]  tok;
  wire [6:0]  dev;
  wire [3:0]  ep, pout;
  wire [9:0]  len, bytes;
  wire [8:0]  baddr;
  integer     n_errors = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  transfer_header_block uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .frame_tick_in(tick), .pkt_req_out(req), .pkt_token_out(tok),
    .pkt_dev_addr_out(dev), .pkt_ep_out(ep), .pkt_low_speed_out(low), .pkt_toggle_out(tog),
    .pkt_len_out(len), .pkt_buf_addr_out(baddr), .pkt_done_in(done), .pkt_retry_in(retry),
    .pkt_outcome_in(pout), .pkt_bytes_in(bytes), .pkt_rx_toggle_in(rxt));
  pkt_engine_model u_eng (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_in(req),
    .len_in(len), .toggle_in(tog), .delay_in(dly), .outcome_in(oc), .bad_tog_in(bad_tog),
    .retry_in(retry_knob),
    .done_out(done), .retry_out(retry), .outcome_out(pout), .bytes_out(bytes),
    .rx_toggle_out(rxt));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single AHB-Lite transfer; hready is sampled as it stood at each edge
  task ahb(input wr, input [31:0] a, input [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    q = hrdata;
  endtask
  task rd(input [31:0] a, input [31:0] e, input [8*8-1:0] nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task pulse;
    tick <= 1'b1;
    @(posedge clk_sys_in);
    tick <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task wait_req;
    integer i;
    i = 0;
    while (req !== 1'b1 && i < 200) begin
      @(posedge clk_sys_in);
      i = i + 1;
    end
  endtask
  task wait_idle;
    integer i;
    i = 0;
    q = 32'h7;
    while (q[2:0] !== 3'h0 && i < 300) begin
      ahb(1'b0, `REG_STATUS, 32'h0);
      i = i + 1;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`REG_CTRL, 32'h0, "ctrl");
    ahb(1'b1, `REG_CTRL, 32'h7);
    rd(`REG_CTRL, 32'h7, "ctrl");
    ahb(1'b1, `REG_FRAME, 32'h1ab);
    rd(`REG_FRAME, 32'hab, "frame");
    ahb(1'b1, 32'h14, 32'hffffffff);
    rd(32'h14, 32'h0, "unmapped");
    ahb(1'b1, `REG_STATUS, 32'hffff);
    rd(`REG_STATUS, 32'h100, "status");
    $display("test regs done");
  endtask
  task t_aper;
    ahb(1'b1, `REG_CTRL, 32'h4);
    ahb(1'b1, `REG_APER_END, 32'h1);
    ahb(1'b1, 32'h200, 32'h54080800);
    ahb(1'b1, 32'h204, 32'h002a0414);
    ahb(1'b1, 32'h220, 32'h30400c00);
    ahb(1'b1, 32'h224, 32'h00110810);
    bad_tog <= 1'b1;
    pulse;
    wait_req;
    chk("ep", 32'h5, ep);
    chk("dev", 32'h2a, dev);
    chk("low", 32'h1, low);
    chk("token", 32'h1, tok);
    chk("len", 32'h8, len);
    chk("toggle", 32'h0, tog);
    chk("bufaddr", 32'h8, baddr);
    wait_idle;
    rd(32'h200, 32'h54080414, "aper0w0");
    rd(32'h204, 32'h002a0414, "aper0w1");
    rd(32'h220, 32'h30403400, "aper1w0");
    bad_tog <= 1'b0;
    $display("test aperiodic done");
  endtask
  task t_err;
    ahb(1'b1, 32'h200, 32'h10010800);
    ahb(1'b1, 32'h204, 32'h00010401);
    oc  <= 4'h4;
    dly <= 4'h0;
    pulse;
    wait_idle;
    rd(32'h200, 32'h10014000, "err0w0");
    rd(32'h220, 32'h30403400, "skip1w0");
    oc  <= 4'h0;
    dly <= 4'h2;
    $display("test error done");
  endtask
  task t_iso;
    ahb(1'b1, `REG_CTRL, 32'h1);
    ahb(1'b1, `REG_FRAME, 32'h10);
    ahb(1'b1, 32'h300, 32'h08040800);
    ahb(1'b1, 32'h304, 32'h12000404);
    ahb(1'b1, 32'h320, 32'h00040800);
    ahb(1'b1, 32'h324, 32'h12000404);
    pulse;
    wait_idle;
    rd(`REG_FRAME, 32'h11, "frame");
    rd(32'h300, 32'h08040800, "iso0miss");
    pulse;
    wait_req;
    chk("bufaddr", 32'h108, baddr);
    wait_idle;
    rd(32'h300, 32'h08040404, "iso0w0");
    rd(32'h320, 32'h00040800, "iso1w0");
    $display("test isochronous done");
  endtask
  // Interrupt slot 0 polled every second frame; slot 1 lies past the list end
  task t_int;
    ahb(1'b1, `REG_CTRL, 32'h2);
    ahb(1'b1, 32'h280, 32'h20100800);
    ahb(1'b1, 32'h284, 32'h20050420);
    ahb(1'b1, 32'h2a0, 32'h20100800);
    pulse;
    wait_idle;
    rd(32'h280, 32'h20100800, "int0miss");
    retry_knob <= 1'b1;
    oc         <= 4'h5;
    pulse;
    wait_req;
    chk("dev", 32'h5, dev);
    chk("len", 32'h10, len);
    wait_idle;
    rd(32'h280, 32'h20105800, "int0rtry");
    retry_knob <= 1'b0;
    oc         <= 4'h0;
    pulse;
    wait_idle;
    pulse;
    wait_idle;
    rd(32'h280, 32'h20100c10, "int0w0");
    rd(32'h2a0, 32'h20100800, "int1w0");
    $display("test interrupt done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    // Whole run needs a few hundred cycles; this only catches a hang
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    t_regs;
    t_aper;
    t_err;
    t_iso;
    t_int;
    wrap_up;
  end
endmodule
